// *** bank_state.v ***
// state tracker for one sdram bank
`timescale 1ns/1ns
`include "sdram_bank_regs.vh"
module bank_state #(
	parameter CW = 8
) (
	input  wire          clk,
	input  wire          rst_n,
	input  wire          run,
	input  wire          act,
	input  wire          rd,
	input  wire          wr,
	input  wire          ap,
	input  wire          pre,
	input  wire          stop,
	input  wire          intr,
	input  wire          burst_done,
	input  wire [CW-1:0] pre_cyc,
	input  wire [CW-1:0] act_cyc,
	input  wire [CW-1:0] wr_cyc,
	output reg  [2:0]    state_q,
	output reg           ap_q
);
	reg  [2:0]    state_d;
	reg  [CW-1:0] cnt_q;
	reg  [CW-1:0] cnt_d;
	reg           ap_d;

	always @* begin
		state_d = state_q;
		cnt_d   = (cnt_q != {CW{1'b0}}) ? cnt_q - 1'b1 : cnt_q;
		ap_d    = ap_q;
		if (!run) begin
			state_d = state_q;
			cnt_d   = cnt_q;
		end else if (act && state_q == `BS_IDLE) begin
			state_d = `BS_ACTIVATING;
			cnt_d   = act_cyc - 1'b1; // [R17]
		end else if (pre && (state_q != `BS_PRECHARGING)) begin
			state_d = `BS_PRECHARGING; // [R11] [R12] [R20]
			cnt_d   = pre_cyc - 1'b1;
			ap_d    = 1'b0;
		end else if (rd || wr) begin
			state_d = rd ? `BS_READ : `BS_WRITE; // [R11] [R12]
			ap_d    = ap;
		end else if (intr && ap_q) begin
			// interrupted auto precharge burst waits write recovery
			state_d = `BS_RECOVERY; // [R2] [R4]
			cnt_d   = wr_cyc - 1'b1;
		end else begin
			case (state_q)
			`BS_ACTIVATING: if (cnt_q == {CW{1'b0}}) state_d = `BS_ROW_ACTIVE; // [R15]
			`BS_PRECHARGING: if (cnt_q == {CW{1'b0}}) state_d = `BS_IDLE; // [R14]
			`BS_RECOVERY: if (cnt_q == {CW{1'b0}}) begin
				state_d = `BS_PRECHARGING;
				cnt_d   = pre_cyc - 1'b1;
				ap_d    = 1'b0;
			end
			`BS_READ, `BS_WRITE: if (stop || burst_done) begin
				if (ap_q && burst_done) begin
					state_d = (state_q == `BS_WRITE) ? `BS_RECOVERY : `BS_PRECHARGING;
					cnt_d   = (state_q == `BS_WRITE) ? wr_cyc - 1'b1 : pre_cyc - 1'b1;
					ap_d    = state_q == `BS_WRITE;
				end else begin
					state_d = `BS_ROW_ACTIVE;
				end
			end
			default: state_d = state_q;
			endcase
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= `BS_IDLE;
			cnt_q   <= {CW{1'b0}};
			ap_q    <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			ap_q    <= ap_d;
		end
	end
endmodule

// *** sdram_bank_command_state_logic.v ***
// command decode, power states and per-bank tracking for a quad-bank sdram
`timescale 1ns/1ns
`include "sdram_bank_regs.vh"
// Contract
// [R1] read to other bank stops auto precharge write; data after read latency
// [R2] interrupted auto precharge write precharges after write recovery from read
// [R3] data one clock before interrupting read is last write to old bank
// [R4] write to other bank interrupting auto precharge write: same recovery rule
// [R5] power transitions use clock-gate level now and at previous edge; exits here check only the current level
// [R6] leaving power-down: all banks idle, command accepted next edge
// [R7] controller sends only nop or inhibit during self refresh exit time
// [R8] leaving clock suspend resumes operation, next command next edge
// [R9] command decode from the four strobes
// [R10] controller sends commands only to banks in fitting states
// [R11] precharge cuts read burst short; read or write also accepted
// [R12] precharge cuts write burst short; read or write also accepted
// [R13] bank rules only with clock-gate high twice and after self refresh exit
// [R14] idle only after precharge and precharge period
// [R15] row active only after activate delay, no burst in progress
// [R16] controller leaves busy banks alone
// [R17] activating and precharging states have timed ends
// [R18] auto refresh holds device busy for refresh cycle time
// [R19] mode load holds device busy for mode load delay
// [R20] precharge all idles all banks after precharge period
// [R21] controller refreshes and loads mode only with all banks idle
// [R22] controller precharges all only from allowed states
// [R23] clock-gate low with nop and no access enters power-down
// [R24] burst terminate stops latest burst of any bank
// [R25] refresh with falling clock-gate and all idle enters self refresh
// [R26] falling clock-gate during burst with write or nop enters suspend
module sdram_bank_command_state_logic #(
	parameter NB = 4,
	parameter CW = 8,
	parameter BURST = `BURST_LEN_CYC
) (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        clk_gate,
	input  wire        chip_sel_n,
	input  wire        row_strobe_n,
	input  wire        col_strobe_n,
	input  wire        write_strobe_n,
	input  wire [1:0]  bank_addr,
	input  wire        auto_pre,
	output reg  [11:0] bank_states,
	output reg  [2:0]  dev_state,
	output reg         all_idle,
	output reg         write_commit,
	output reg  [1:0]  write_commit_bank,
	output reg         read_data_valid,
	output reg  [1:0]  read_data_bank,
	output reg         cmd_accepted
);
	localparam [CW-1:0] PRE_CYC = `PRECHARGE_CYC;
	localparam [CW-1:0] ACT_CYC = `ACT_TO_ACCESS_CYC;
	localparam [CW-1:0] WR_CYC  = `WRITE_RECOVERY_CYC;
	localparam [CW-1:0] RC_CYC  = `REFRESH_CYCLE_CYC;
	localparam [CW-1:0] MRD_CYC = `MODE_LOAD_DELAY_CYC;
	localparam [CW-1:0] XSR_CYC = `SELF_REFRESH_EXIT_CYC;
	localparam [CW-1:0] BL      = BURST;
	localparam RL = `READ_LATENCY_CYC;

	////////////////////////////////////////////////////////////////////////
	// decode
	wire [3:0] cmd = {chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n};
	wire is_inh  = chip_sel_n; // [R9]
	wire is_nop  = is_inh || cmd == `CMD_NOP;
	wire is_act  = !is_inh && cmd == `CMD_ACTIVE;
	wire is_rd   = !is_inh && cmd == `CMD_READ;
	wire is_wr   = !is_inh && cmd == `CMD_WRITE;
	wire is_pre  = !is_inh && cmd == `CMD_PRECHARGE;
	wire is_ref  = !is_inh && cmd == `CMD_REFRESH;
	wire is_lmr  = !is_inh && cmd == `CMD_LOAD_MODE;
	wire is_bst  = !is_inh && cmd == `CMD_BURST_TERM;
	// auto_pre doubles as the precharge-all select on a precharge
	wire pre_all = is_pre && auto_pre;

	reg        gate_prev_q;
	reg [2:0]  dstate_q;
	reg [2:0]  dstate_d;
	reg [CW-1:0] dcnt_q;
	reg [CW-1:0] dcnt_d;
	reg [CW-1:0] bcnt_q;
	reg [CW-1:0] bcnt_d;
	reg        burst_on_q;
	reg        burst_on_d;
	reg        burst_wr_q;
	reg        burst_wr_d;
	reg [1:0]  burst_bank_q;
	reg [1:0]  burst_bank_d;
	reg [RL-1:0] rpipe_v_q;
	reg [2*RL-1:0] rpipe_b_q;

	wire [3*NB-1:0] bst;
	wire [NB-1:0]   idle_v;
	wire [NB-1:0]   busy_v;

	// [R5] [R13] bank commands only with gate high at both edges
	wire normal = dstate_q == `DS_NORMAL && gate_prev_q && clk_gate;
	wire all_ok = &idle_v;
	wire access = |busy_v || burst_on_q;
	wire new_burst = normal && (is_rd || is_wr);

	////////////////////////////////////////////////////////////////////////
	// device power and refresh states
	always @* begin
		dstate_d = dstate_q;
		dcnt_d   = (dcnt_q != {CW{1'b0}}) ? dcnt_q - 1'b1 : dcnt_q;
		case (dstate_q)
		`DS_NORMAL: begin
			if (gate_prev_q && !clk_gate) begin // [R5]
				if (is_ref && all_ok)
					dstate_d = `DS_SELF_REF; // [R25]
				else if (burst_on_q && (is_nop || is_wr))
					dstate_d = `DS_SUSPEND; // [R26]
				else if (is_nop && !burst_on_q)
					dstate_d = `DS_POWER_DOWN; // [R23]
			end else if (normal && is_ref) begin
				dstate_d = `DS_REFRESHING; // [R18]
				dcnt_d   = RC_CYC - 1'b1;
			end else if (normal && is_lmr) begin
				dstate_d = `DS_MODE_LOAD; // [R19]
				dcnt_d   = MRD_CYC - 1'b1;
			end
		end
		`DS_POWER_DOWN: if (clk_gate && is_nop) dstate_d = `DS_NORMAL; // [R6]
		`DS_SELF_REF: if (clk_gate && is_nop) begin
			dstate_d = `DS_SELF_EXIT;
			dcnt_d   = XSR_CYC - 1'b1;
		end
		// bank commands not accepted until exit time passes [R13] [R7]
		`DS_SELF_EXIT: if (dcnt_q == {CW{1'b0}}) dstate_d = `DS_NORMAL;
		`DS_SUSPEND: if (clk_gate) dstate_d = `DS_NORMAL; // [R8]
		`DS_REFRESHING, `DS_MODE_LOAD:
			if (dcnt_q == {CW{1'b0}}) dstate_d = `DS_NORMAL; // [R18] [R19]
		default: dstate_d = `DS_NORMAL;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// most recent burst tracking, shared by all banks
	wire frozen = dstate_q == `DS_SUSPEND || dstate_d == `DS_SUSPEND;
	wire cut = normal && (is_bst || (is_pre && (pre_all || bank_addr == burst_bank_q)));
	wire done = burst_on_q && !frozen && bcnt_q == {{(CW-1){1'b0}}, 1'b1};
	always @* begin
		burst_on_d   = burst_on_q;
		burst_wr_d   = burst_wr_q;
		burst_bank_d = burst_bank_q;
		bcnt_d       = bcnt_q;
		if (new_burst) begin
			burst_on_d   = 1'b1;
			burst_wr_d   = is_wr;
			burst_bank_d = bank_addr;
			bcnt_d       = BL;
		end else if (cut || done) begin
			burst_on_d = 1'b0; // [R24]
			bcnt_d     = {CW{1'b0}};
		end else if (burst_on_q && !frozen) begin
			bcnt_d = bcnt_q - 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// banks
	genvar g;
	generate
		for (g = 0; g < NB; g = g + 1) begin : bank
			wire sel = bank_addr == g;
			wire mine = burst_bank_q == g;
			// burst on this bank preempted by an access to another [R1] [R4]
			wire intr = new_burst && !sel && burst_on_q && mine;
			bank_state #(.CW(CW)) u_bank (
				.clk       (clk),
				.rst_n     (rst_n),
				.run       (!frozen),
				.act       (normal && is_act && sel),
				.rd        (normal && is_rd && sel),
				.wr        (normal && is_wr && sel),
				.ap        (auto_pre),
				.pre       (normal && is_pre && (sel || pre_all)),
				.stop      ((cut || intr) && mine),
				.intr      (intr),
				.burst_done(done && mine),
				.pre_cyc   (PRE_CYC),
				.act_cyc   (ACT_CYC),
				.wr_cyc    (WR_CYC),
				.state_q   (bst[3*g+2:3*g]),
				.ap_q      ()
			);
			assign idle_v[g] = bst[3*g+2:3*g] == `BS_IDLE;
			assign busy_v[g] = bst[3*g+2:3*g] == `BS_READ || bst[3*g+2:3*g] == `BS_WRITE;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// registers and outputs
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gate_prev_q       <= 1'b1;
			dstate_q          <= `DS_NORMAL;
			dcnt_q            <= {CW{1'b0}};
			bcnt_q            <= {CW{1'b0}};
			burst_on_q        <= 1'b0;
			burst_wr_q        <= 1'b0;
			burst_bank_q      <= 2'h0;
			rpipe_v_q         <= {RL{1'b0}};
			rpipe_b_q         <= {(2*RL){1'b0}};
			bank_states       <= 12'h000;
			dev_state         <= 3'h0;
			all_idle          <= 1'b1;
			write_commit      <= 1'b0;
			write_commit_bank <= 2'h0;
			read_data_valid   <= 1'b0;
			read_data_bank    <= 2'h0;
			cmd_accepted      <= 1'b0;
		end else begin
			gate_prev_q  <= clk_gate; // [R5]
			dstate_q     <= dstate_d;
			dcnt_q       <= dcnt_d;
			bcnt_q       <= bcnt_d;
			burst_on_q   <= burst_on_d;
			burst_wr_q   <= burst_wr_d;
			burst_bank_q <= burst_bank_d;
			// read data after read latency, no beat pushed while suspended
			rpipe_v_q <= {rpipe_v_q[RL-2:0], burst_on_d && !burst_wr_d && !frozen}; // [R1]
			rpipe_b_q <= {rpipe_b_q[2*RL-3:0], burst_bank_d};
			read_data_valid <= rpipe_v_q[RL-1];
			read_data_bank  <= rpipe_b_q[2*RL-1:2*RL-2];
			// data is written only on edges where the write burst stays live;
			// an interrupting command edge writes nothing to the old bank [R3] [R4]
			write_commit      <= burst_on_q && burst_wr_q && !frozen && !cut && !new_burst && !done
				|| (normal && is_wr);
			write_commit_bank <= (normal && is_wr) ? bank_addr : burst_bank_q;
			bank_states  <= bst;
			dev_state    <= dstate_d;
			all_idle     <= all_ok && !access;
			cmd_accepted <= normal && !is_nop; // [R6] [R8]
		end
	end
endmodule

// *** sdram_bank_command_state_logic_chk.sv ***
// port assertions for the sdram bank command state logic
`timescale 1ns/1ns
`include "sdram_bank_regs.vh"
module sdram_bank_chk #(
	parameter BURST = 4
) (
	input wire        clk,
	input wire        rst_n,
	input wire        clk_gate,
	input wire        chip_sel_n,
	input wire        row_strobe_n,
	input wire        col_strobe_n,
	input wire        write_strobe_n,
	input wire [1:0]  bank_addr,
	input wire        auto_pre,
	input wire [11:0] bank_states,
	input wire [2:0]  dev_state,
	input wire        all_idle,
	input wire        write_commit,
	input wire [1:0]  write_commit_bank,
	input wire        read_data_valid,
	input wire [1:0]  read_data_bank,
	input wire        cmd_accepted
);
	wire [3:0] cmd = {chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n};
	wire [2:0] b0 = bank_states[2:0];
	wire [2:0] bs = bank_states[bank_addr*3 +: 3];
	reg        gate_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) gate_q <= 1'b1;
		else gate_q <= clk_gate;
	end
	// a command counts only with the gate high at both edges
	wire take = clk_gate && gate_q && dev_state == `DS_NORMAL;
	wire rd_take = take && cmd == `CMD_READ && bs >= `BS_ROW_ACTIVE && bs <= `BS_WRITE;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_accept; cmd_accepted |-> $past(take && !chip_sel_n && cmd != `CMD_NOP); endproperty
	a_accept: assert property (p_accept) else $error("accept without command");
	property p_read_lat; rd_take |-> ##[3:5] read_data_valid; endproperty
	a_read_lat: assert property (p_read_lat) else $error("read data late");
	property p_act_len; b0 == `BS_ROW_ACTIVE && $past(b0) == `BS_ACTIVATING |->
		$past(b0, 2) == `BS_ACTIVATING; endproperty
	a_act_len: assert property (p_act_len) else $error("activate too short");
	property p_pre_len; b0 == `BS_PRECHARGING && $past(b0) != `BS_PRECHARGING |->
		##[1:3] b0 == `BS_IDLE; endproperty
	a_pre_len: assert property (p_pre_len) else $error("precharge not ended");
	property p_refresh; dev_state == `DS_REFRESHING && $past(dev_state) != `DS_REFRESHING |->
		(dev_state == `DS_REFRESHING) [*5] ##[1:4] (dev_state == `DS_NORMAL && all_idle); endproperty
	a_refresh: assert property (p_refresh) else $error("refresh window wrong");
	property p_mode; dev_state == `DS_MODE_LOAD && $past(dev_state) != `DS_MODE_LOAD |->
		##[1:3] (dev_state == `DS_NORMAL && all_idle); endproperty
	a_mode: assert property (p_mode) else $error("mode load window wrong");
	property p_pd_in; dev_state == `DS_POWER_DOWN && $past(dev_state) != `DS_POWER_DOWN |->
		$past(!clk_gate && gate_q); endproperty
	a_pd_in: assert property (p_pd_in) else $error("power-down without gate fall");
	property p_pd_out; $past(dev_state) == `DS_POWER_DOWN && dev_state != `DS_POWER_DOWN |->
		dev_state == `DS_NORMAL && $past(clk_gate); endproperty
	a_pd_out: assert property (p_pd_out) else $error("power-down exit wrong");
	property p_sr_exit; dev_state == `DS_SELF_EXIT && $past(dev_state) == `DS_SELF_REF |->
		(dev_state == `DS_SELF_EXIT) [*6]; endproperty
	a_sr_exit: assert property (p_sr_exit) else $error("self refresh exit short");
	property p_susp_out; $past(dev_state) == `DS_SUSPEND && dev_state != `DS_SUSPEND |->
		dev_state == `DS_NORMAL && $past(clk_gate); endproperty
	a_susp_out: assert property (p_susp_out) else $error("suspend exit wrong");
	c_read: cover property (read_data_valid);
	c_susp: cover property (dev_state == `DS_SUSPEND);
	c_sr: cover property (dev_state == `DS_SELF_EXIT);
endmodule
bind sdram_bank_command_state_logic sdram_bank_chk #(.BURST(BURST)) u_chk (
	.clk(clk), .rst_n(rst_n), .clk_gate(clk_gate), .chip_sel_n(chip_sel_n),
	.row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
	.write_strobe_n(write_strobe_n), .bank_addr(bank_addr), .auto_pre(auto_pre),
	.bank_states(bank_states), .dev_state(dev_state), .all_idle(all_idle),
	.write_commit(write_commit), .write_commit_bank(write_commit_bank),
	.read_data_valid(read_data_valid), .read_data_bank(read_data_bank),
	.cmd_accepted(cmd_accepted));

// *** sdram_bank_command_state_logic_tb.sv ***
// self-checking testbench for the sdram bank command state logic
`timescale 1ns/1ns
`include "sdram_bank_regs.vh"
module sdram_bank_command_state_logic_tb;
	logic        clk;
	logic        rst_n;
	wire         clk_gate, chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n, auto_pre;
	wire [1:0]   bank_addr, write_commit_bank, read_data_bank;
	wire [11:0]  bank_states;
	wire [2:0]   dev_state;
	wire         all_idle, write_commit, read_data_valid, cmd_accepted;
	int          fail_count, total_checks;
	int          wc[4], rc[4];
	sdram_ctl_model m (.clk(clk), .clk_gate(clk_gate), .chip_sel_n(chip_sel_n),
		.row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
		.write_strobe_n(write_strobe_n), .bank_addr(bank_addr), .auto_pre(auto_pre));
	sdram_bank_command_state_logic DUT (.clk(clk), .rst_n(rst_n), .clk_gate(clk_gate),
		.chip_sel_n(chip_sel_n), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
		.write_strobe_n(write_strobe_n), .bank_addr(bank_addr), .auto_pre(auto_pre),
		.bank_states(bank_states), .dev_state(dev_state), .all_idle(all_idle),
		.write_commit(write_commit), .write_commit_bank(write_commit_bank),
		.read_data_valid(read_data_valid), .read_data_bank(read_data_bank),
		.cmd_accepted(cmd_accepted));
	always #5 clk = ~clk;
	always @(posedge clk) begin
		if (write_commit === 1'b1) wc[write_commit_bank]++;
		if (read_data_valid === 1'b1) rc[read_data_bank]++;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input [11:0] e, input [11:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic [2:0] cur(input int sel);
		cur = (sel < 4) ? bank_states[sel*3 +: 3] : dev_state;
	endfunction
	// bounded wait with the bus idle; sel 4 watches the device state
	task automatic wt(input int sel, input [2:0] s, input int n);
		for (int i = 0; i < n && cur(sel) !== s; i++) m.nop();
		chk("state", {9'h0, s}, {9'h0, cur(sel)});
	endtask
	task automatic clr;
		wc = '{0, 0, 0, 0};
		rc = '{0, 0, 0, 0};
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk("banks", 12'h0, bank_states);
		chk("idle", 12'h1, {11'h0, all_idle});
		chk("dev", 12'h0, {9'h0, dev_state});
	endtask
	task automatic t_act_pre;
		m.put(`CMD_ACTIVE, 2'h0, 1'b0, 1'b1);
		wt(0, `BS_ACTIVATING, 2);
		wt(0, `BS_ROW_ACTIVE, 3);
		m.put(`CMD_PRECHARGE, 2'h0, 1'b0, 1'b1);
		wt(0, `BS_PRECHARGING, 2);
		wt(0, `BS_IDLE, 3);
	endtask
	task automatic t_concurrent;
		m.put(`CMD_ACTIVE, 2'h0, 1'b0, 1'b1);
		m.put(`CMD_ACTIVE, 2'h1, 1'b0, 1'b1);
		wt(1, `BS_ROW_ACTIVE, 4);
		clr();
		m.put(`CMD_WRITE, 2'h0, 1'b1, 1'b1);
		m.nop();
		m.put(`CMD_READ, 2'h1, 1'b0, 1'b1);
		wt(0, `BS_RECOVERY, 3);
		wt(0, `BS_PRECHARGING, 4);
		wt(0, `BS_IDLE, 4);
		repeat (4) m.nop();
		chk("old bank beats", 12'h2, 12'(wc[0]));
		chk("read beats", 12'h4, 12'(rc[1]));
		m.put(`CMD_ACTIVE, 2'h0, 1'b0, 1'b1);
		wt(0, `BS_ROW_ACTIVE, 4);
		clr();
		m.put(`CMD_WRITE, 2'h0, 1'b1, 1'b1);
		m.put(`CMD_WRITE, 2'h1, 1'b0, 1'b1);
		wt(0, `BS_RECOVERY, 3);
		wt(0, `BS_IDLE, 8);
		repeat (3) m.nop();
		chk("old bank beats", 12'h1, 12'(wc[0]));
		chk("new bank beats", 12'h4, 12'(wc[1]));
	endtask
	task automatic t_trunc;
		m.put(`CMD_READ, 2'h1, 1'b0, 1'b1);
		m.put(`CMD_PRECHARGE, 2'h1, 1'b0, 1'b1);
		wt(1, `BS_PRECHARGING, 2);
		wt(1, `BS_IDLE, 3);
		m.put(`CMD_ACTIVE, 2'h1, 1'b0, 1'b1);
		wt(1, `BS_ROW_ACTIVE, 4);
		clr();
		m.put(`CMD_WRITE, 2'h1, 1'b0, 1'b1);
		m.put(`CMD_BURST_TERM, 2'h1, 1'b0, 1'b1);
		repeat (4) m.nop();
		chk("terminated beats", 12'h1, 12'(wc[1]));
		m.put(`CMD_WRITE, 2'h1, 1'b0, 1'b1);
		m.put(`CMD_PRECHARGE, 2'h1, 1'b0, 1'b1);
		wt(1, `BS_PRECHARGING, 2);
		wt(1, `BS_IDLE, 3);
	endtask
	task automatic t_power;
		m.put(`CMD_NOP, 2'h0, 1'b0, 1'b0);
		wt(4, `DS_POWER_DOWN, 2);
		m.nop();
		m.put(`CMD_NOP, 2'h0, 1'b0, 1'b1);
		m.put(`CMD_ACTIVE, 2'h2, 1'b0, 1'b1);
		wt(2, `BS_ACTIVATING, 2);
		wt(2, `BS_ROW_ACTIVE, 3);
		m.put(`CMD_PRECHARGE, 2'h2, 1'b0, 1'b1);
		wt(2, `BS_IDLE, 5);
	endtask
	task automatic t_refresh;
		m.put(`CMD_REFRESH, 2'h0, 1'b0, 1'b1);
		wt(4, `DS_REFRESHING, 2);
		wt(4, `DS_NORMAL, 9);
		chk("idle", 12'h1, {11'h0, all_idle});
		m.put(`CMD_LOAD_MODE, 2'h0, 1'b0, 1'b1);
		wt(4, `DS_MODE_LOAD, 2);
		wt(4, `DS_NORMAL, 4);
		m.put(`CMD_REFRESH, 2'h0, 1'b0, 1'b0);
		wt(4, `DS_SELF_REF, 2);
		repeat (3) m.nop();
		m.put(`CMD_NOP, 2'h0, 1'b0, 1'b1);
		wt(4, `DS_SELF_EXIT, 2);
		wt(4, `DS_NORMAL, 10);
	endtask
	task automatic t_suspend;
		m.put(`CMD_ACTIVE, 2'h3, 1'b0, 1'b1);
		wt(3, `BS_ROW_ACTIVE, 4);
		clr();
		m.put(`CMD_READ, 2'h3, 1'b0, 1'b1);
		m.nop();
		m.put(`CMD_NOP, 2'h0, 1'b0, 1'b0);
		wt(4, `DS_SUSPEND, 2);
		m.nop();
		m.put(`CMD_NOP, 2'h0, 1'b0, 1'b1);
		wt(4, `DS_NORMAL, 2);
		repeat (6) m.nop();
		chk("resumed beats", 12'h4, 12'(rc[3]));
		m.put(`CMD_PRECHARGE, 2'h0, 1'b1, 1'b1);
		wt(3, `BS_IDLE, 4);
		chk("idle", 12'h1, {11'h0, all_idle});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		t_reset();
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_act_pre();
		t_concurrent();
		t_trunc();
		t_power();
		t_refresh();
		t_suspend();
		end_of_test();
	end
	// whole run is well under two hundred cycles
	initial begin
		#100000;
		fail_count++;
		end_of_test();
	end
endmodule

// *** sdram_bank_regs.vh ***
// timing constants and encodings for the sdram bank command state logic
`ifndef SDRAM_BANK_REGS_VH
`define SDRAM_BANK_REGS_VH

`define CLK_PERIOD_NS          10
`define PRECHARGE_PERIOD_NS    20
`define ACT_TO_ACCESS_NS       20
`define WRITE_RECOVERY_NS      14
`define REFRESH_CYCLE_NS       70
`define MODE_LOAD_DELAY_NS     20
`define SELF_REFRESH_EXIT_NS   80
`define READ_LATENCY_CYC       3
`define BURST_LEN_CYC          4

// least times, rounded up to whole cycles
`define CYC_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRECHARGE_CYC          `CYC_UP(`PRECHARGE_PERIOD_NS)
`define ACT_TO_ACCESS_CYC      `CYC_UP(`ACT_TO_ACCESS_NS)
`define WRITE_RECOVERY_CYC     `CYC_UP(`WRITE_RECOVERY_NS)
`define REFRESH_CYCLE_CYC      `CYC_UP(`REFRESH_CYCLE_NS)
`define MODE_LOAD_DELAY_CYC    `CYC_UP(`MODE_LOAD_DELAY_NS)
`define SELF_REFRESH_EXIT_CYC  `CYC_UP(`SELF_REFRESH_EXIT_NS)

// command codes {cs,ras,cas,we}
`define CMD_NOP        4'b0111
`define CMD_ACTIVE     4'b0011
`define CMD_READ       4'b0101
`define CMD_WRITE      4'b0100
`define CMD_PRECHARGE  4'b0010
`define CMD_REFRESH    4'b0001
`define CMD_LOAD_MODE  4'b0000
`define CMD_BURST_TERM 4'b0110

// bank states
`define BS_IDLE        3'h0
`define BS_ACTIVATING  3'h1
`define BS_ROW_ACTIVE  3'h2
`define BS_READ        3'h3
`define BS_WRITE       3'h4
`define BS_PRECHARGING 3'h5
`define BS_RECOVERY    3'h6

// device states
`define DS_NORMAL      3'h0
`define DS_POWER_DOWN  3'h1
`define DS_SELF_REF    3'h2
`define DS_SELF_EXIT   3'h3
`define DS_SUSPEND     3'h4
`define DS_REFRESHING  3'h5
`define DS_MODE_LOAD   3'h6

`endif

// *** sdram_ctl_model.sv ***
// controller model driving commands and the clock gate into the bank logic
`timescale 1ns/1ns
`include "sdram_bank_regs.vh"
module sdram_ctl_model (
	input  wire        clk,
	output logic       clk_gate,
	output logic       chip_sel_n,
	output logic       row_strobe_n,
	output logic       col_strobe_n,
	output logic       write_strobe_n,
	output logic [1:0] bank_addr,
	output logic       auto_pre
);
	initial begin
		clk_gate = 1'b1;
		{chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n} = `CMD_NOP;
		bank_addr = 2'h0;
		auto_pre = 1'b0;
	end
	// callers send only what the target bank state allows
	task automatic put(input [3:0] c, input [1:0] b, input a, input g);
		@(posedge clk);
		{chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n} <= c;
		bank_addr <= b;
		auto_pre <= a;
		clk_gate <= g;
		#1;
	endtask
	// idle slots fill busy windows; don't-care lines toggle
	task automatic nop;
		put(`CMD_NOP, ~bank_addr, ~auto_pre, clk_gate);
	endtask
endmodule
